//--- design/dfa_defs.vh
// register map, field layout and timing constants of the frequency aux block
`ifndef DFA_DEFS_VH
`define DFA_DEFS_VH
`define DFA_ADDR_CTRL     8'h00
`define DFA_ADDR_JUMP     8'h04
`define DFA_ADDR_AMPDEAD  8'h08
`define DFA_ADDR_DROOP    8'h0c
`define DFA_RAMP_PAGE     4'h1
`define DFA_ADDR_HOURS    8'h20
`define DFA_ADDR_LEVEL    8'h24
`define DFA_ADDR_ARRIVE   8'h28
`define DFA_ADDR_LIMITS   8'h2c
`define DFA_ADDR_DOSEL    8'h30
`define DFA_ADDR_STATUS   8'h34
`define DFA_ADDR_IRQSTAT  8'h38
`define DFA_ADDR_IRQMASK  8'h3c
`define DFA_LO            15:0
`define DFA_HI            31:16
`define DFA_CTRL_PROT     0
`define DFA_CTRL_LLM      2:1
`define DFA_CTRL_NOREV    3
`define DFA_CTRL_START    5:4
`define DFA_CTRL_STOP     6
`define DFA_CTRL_RST      7'h00
`define DFA_LLM_LIMIT     2'h0
`define DFA_LLM_STOP      2'h1
`define DFA_STOP_DECEL    1'b0
`define DFA_START_DIRECT  2'h0
`define DFA_RAMP_MAX      16'hfde8
`define DFA_DEAD_MAX      16'h7530
`define DFA_HOURS_MAX     16'hfde8
`define DFA_PCT2_MAX      16'h2710
`define DFA_PCT1_MAX      16'h03e8
`define DFA_PCT2_FULL     48'h2710
`define DFA_PCT1_FULL     48'h3e8
`define DFA_DROOP_DIV     48'hf4240
`define DFA_LEVEL_RST     32'h01f4_1388
`define DFA_DO_RUNNING    6'h01
`define DFA_DO_LEVEL      6'h03
`define DFA_DO_ARRIVE     6'h04
`define DFA_DO_RUNTIME    6'h0c
`define DFA_DO_POWERON    6'h18
`define DFA_IRQ_LEVEL     0
`define DFA_IRQ_ARRIVE    1
`define DFA_IRQ_POWERON   2
`define DFA_IRQ_RUNTIME   3
`define DFA_IRQ_LOCKOUT   4
`define DFA_ST_IDLE       2'h0
`define DFA_ST_RUN        2'h1
`define DFA_ST_DEAD       2'h2
`define DFA_TENTH_S_NS    100000000
`define DFA_CLK_NS        50
`endif

//--- design/dfa_aux_logic.v
// frequency auxiliary logic: ramps, jumps, reversal dead time, detections
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "dfa_defs.vh"
module dfa_aux_logic #(
  parameter TENTH_CYC        = `DFA_TENTH_S_NS / `DFA_CLK_NS,
  parameter PROTECT_AT_RESET = 1'b0
) (
  input  wire        ref_clk,
  input  wire        srst,
  input  wire [7:0]  busAddr,
  input  wire [31:0] busWdata,
  input  wire        busWr,
  input  wire        busRd,
  output reg  [31:0] busRdata,
  input  wire        runCmd,
  input  wire        reverseCmd,
  input  wire        jogCmd,
  input  wire        faultReset,
  input  wire [1:0]  multiFunctionInput,
  input  wire [15:0] setFrequency,
  input  wire [15:0] outputTorque,
  input  wire [15:0] accumulatedPowerOnHours,
  input  wire [15:0] accumulatedRunHours,
  output reg  [15:0] outFreq,
  output reg         outReverse,
  output reg         running,
  output reg  [1:0]  startMethod,
  output reg         stopMethod,
  output reg         frequencyLevelDetect,
  output reg         frequencyArrival,
  output reg  [3:0]  multiFunctionOutput,
  output reg         irq
);

  reg [6:0]  ctrl;
  reg [31:0] jumpPts;
  reg [31:0] ampDead;
  reg [15:0] droopRate;
  reg [31:0] rampTime [0:3];
  reg [31:0] hourThr;
  reg [31:0] levelCfg;
  reg [31:0] arriveCfg;
  reg [31:0] limits;
  reg [23:0] doSel;
  reg [4:0]  irqStat;
  reg [4:0]  irqMask;
  reg [1:0]  state;
  reg [15:0] rampFreq;
  reg [47:0] rampAcc;
  reg [31:0] tenthCnt;
  reg [15:0] deadCnt;
  reg        lockout;
  reg        armed;
  reg        powerOnArr;
  reg        runTimeArr;
  integer    i;

  function [15:0] clampTo;
    input [15:0] v;
    input [15:0] mx;
    begin
      clampTo = (v > mx) ? mx : v;
    end
  endfunction

  function [31:0] clampPair;
    input [31:0] v;
    input [15:0] mxLo;
    input [15:0] mxHi;
    begin
      clampPair = {clampTo(v[`DFA_HI], mxHi), clampTo(v[`DFA_LO], mxLo)};
    end
  endfunction

  function rampPage;
    input [7:0] a;
    begin
      rampPage = (a[7:4] == `DFA_RAMP_PAGE);
    end
  endfunction

  // point +/- amplitude
  // band edges are exclusive, a tie goes to the lower edge
  function [15:0] jumpOne;
    input [15:0] f;
    input [15:0] p;
    input [15:0] amp;
    reg   [16:0] lo;
    reg   [16:0] hi;
    reg   [16:0] fw;
    begin
      lo = (p > amp) ? {1'b0, p - amp} : 17'h0;
      hi = {1'b0, p} + {1'b0, amp};
      fw = {1'b0, f};
      jumpOne = f;
      if (fw > lo && fw < hi) begin
        if (fw - lo <= hi - fw) begin
          jumpOne = lo[15:0];
        end else begin
          jumpOne = (hi[16]) ? 16'hffff : hi[15:0];
        end
      end
    end
  endfunction

  function doFunc;
    input [5:0] code;
    input       runBit;
    input       levelBit;
    input       arriveBit;
    input       runTimeBit;
    input       powerOnBit;
    begin
      case (code)
        `DFA_DO_RUNNING: doFunc = runBit;
        `DFA_DO_LEVEL:   doFunc = levelBit;
        `DFA_DO_ARRIVE:  doFunc = arriveBit;
        `DFA_DO_RUNTIME: doFunc = runTimeBit;
        `DFA_DO_POWERON: doFunc = powerOnBit;
        default:         doFunc = 1'b0;
      endcase
    end
  endfunction

  // target frequency path
  wire        cmdAny    = runCmd | jogCmd;
  wire        notIdle   = state != `DFA_ST_IDLE;
  // jump bands apply to the jog frequency too
  wire [15:0] baseF     = jogCmd ? limits[`DFA_HI] : setFrequency;
  wire [15:0] jumpAmp   = ampDead[`DFA_LO];
  wire [15:0] deadTime  = ampDead[`DFA_HI];
  wire [15:0] lowLimit  = limits[`DFA_LO];
  wire [15:0] maxFreq   = arriveCfg[`DFA_HI];
  wire        jumpOff   = (jumpPts == 32'h0);
  wire [15:0] jumpA     = jumpOne(baseF, jumpPts[`DFA_LO], jumpAmp);
  wire [15:0] jumpB     = jumpOne(jumpA, jumpPts[`DFA_HI], jumpAmp);
  wire [15:0] jumpedF   = jumpOff ? baseF : jumpB;
  wire        belowLim  = jumpedF < lowLimit;
  wire [1:0]  llMode    = ctrl[`DFA_CTRL_LLM];
  wire        llStop    = belowLim && llMode == `DFA_LLM_STOP;
  wire [15:0] limF      = !belowLim ? jumpedF :
                          (llMode == `DFA_LLM_LIMIT) ? lowLimit : 16'h0;
  wire        reqRun    = cmdAny && !lockout && !llStop;
  wire        wantRev   = reverseCmd && !ctrl[`DFA_CTRL_NOREV];
  wire        dirOk     = (outReverse == wantRev);
  wire [15:0] tgt       = (reqRun && state == `DFA_ST_RUN && dirOk) ? limF : 16'h0;

  wire [31:0] rampSet   = rampTime[multiFunctionInput];
  wire        accel     = rampFreq < tgt;
  wire [15:0] rampSel   = accel ? rampSet[`DFA_LO] : rampSet[`DFA_HI];
  wire [47:0] rampLimit = rampSel * TENTH_CYC;
  wire [47:0] accSum    = rampAcc + {32'h0, maxFreq};
  // at most one 0.01 Hz step per clock, so very short ramps run slower
  // than set; keep TENTH_CYC large enough for the ramp range in use
  wire        stepNow   = accSum >= rampLimit;
  wire        coast     = !reqRun && !jogCmd && ctrl[`DFA_CTRL_STOP] != `DFA_STOP_DECEL;

  // droop = f x torque x rate / 1000000
  wire [47:0] droopProd = rampFreq * outputTorque * droopRate;
  wire [47:0] droopQ    = droopProd / `DFA_DROOP_DIV;
  // capped so the frequency never wraps below zero
  wire [15:0] droopHz   = (droopQ > {32'h0, rampFreq}) ? rampFreq : droopQ[15:0];
  wire [15:0] nextFreq  = rampFreq - droopHz;

  // detections
  wire [15:0] lvlThr    = levelCfg[`DFA_LO];
  wire [31:0] lvlHyst   = lvlThr * levelCfg[`DFA_HI];
  wire [47:0] lvlHystQ  = {16'h0, lvlHyst} / `DFA_PCT2_FULL;
  wire [15:0] lvlOff    = lvlThr - lvlHystQ[15:0];
  // on above value, off below hysteresis
  wire        nextLevel = frequencyLevelDetect ? !(nextFreq < lvlOff) : (nextFreq > lvlThr);
  wire [31:0] bandProd  = maxFreq * arriveCfg[`DFA_LO];
  wire [47:0] bandQ     = {16'h0, bandProd} / `DFA_PCT1_FULL;
  wire [15:0] freqDiff  = (nextFreq > limF) ? nextFreq - limF : limF - nextFreq;
  wire        nextArr   = (state == `DFA_ST_RUN) && (freqDiff <= bandQ[15:0]);
  wire        nextPwr   = accumulatedPowerOnHours >= hourThr[`DFA_LO];
  wire        nextRunT  = accumulatedRunHours >= hourThr[`DFA_HI];
  wire        nextLock  = !cmdAny ? 1'b0 :
                          (ctrl[`DFA_CTRL_PROT] && (armed || faultReset)) ? 1'b1 : lockout;

  wire [4:0]  events;
  assign events[`DFA_IRQ_LEVEL]   = nextLevel && !frequencyLevelDetect;
  assign events[`DFA_IRQ_ARRIVE]  = nextArr && !frequencyArrival;
  assign events[`DFA_IRQ_POWERON] = nextPwr && !powerOnArr;
  assign events[`DFA_IRQ_RUNTIME] = nextRunT && !runTimeArr;
  assign events[`DFA_IRQ_LOCKOUT] = nextLock && !lockout;
  wire        clrStat   = busWr && busAddr == `DFA_ADDR_IRQSTAT;
  // set wins over a write-one clear
  wire [4:0]  nextStat  = (irqStat & ~(clrStat ? busWdata[4:0] : 5'h0)) | events;

  reg [31:0] rdMux;
  always @* begin
    rdMux = 32'h0;
    if (rampPage(busAddr)) begin
      rdMux = rampTime[busAddr[3:2]];
    end else begin
      case (busAddr)
        `DFA_ADDR_CTRL:    rdMux = {25'h0, ctrl};
        `DFA_ADDR_JUMP:    rdMux = jumpPts;
        `DFA_ADDR_AMPDEAD: rdMux = ampDead;
        `DFA_ADDR_DROOP:   rdMux = {16'h0, droopRate};
        `DFA_ADDR_HOURS:   rdMux = hourThr;
        `DFA_ADDR_LEVEL:   rdMux = levelCfg;
        `DFA_ADDR_ARRIVE:  rdMux = arriveCfg;
        `DFA_ADDR_LIMITS:  rdMux = limits;
        `DFA_ADDR_DOSEL:   rdMux = {8'h0, doSel};
        `DFA_ADDR_STATUS:  rdMux = {state, lockout, runTimeArr, powerOnArr, frequencyArrival,
                                    frequencyLevelDetect, outReverse, running, 7'h0, outFreq};
        `DFA_ADDR_IRQSTAT: rdMux = {27'h0, irqStat};
        `DFA_ADDR_IRQMASK: rdMux = {27'h0, irqMask};
        default:           rdMux = 32'h0;
      endcase
    end
  end

  // register file
  always @(posedge ref_clk) begin
    if (srst) begin
      ctrl      <= `DFA_CTRL_RST | {6'h0, PROTECT_AT_RESET[0]};
      jumpPts   <= 32'h0;
      ampDead   <= 32'h0;
      droopRate <= 16'h0;
      hourThr   <= 32'h0;
      levelCfg  <= `DFA_LEVEL_RST;
      arriveCfg <= 32'h0;
      limits    <= 32'h0;
      doSel     <= 24'h0;
      irqMask   <= 5'h0;
      irqStat   <= 5'h0;
      busRdata  <= 32'h0;
      for (i = 0; i < 4; i = i + 1) begin
        rampTime[i] <= 32'h0;
      end
    end else begin
      irqStat  <= nextStat;
      // read data stands one cycle, zero otherwise
      busRdata <= busRd ? rdMux : 32'h0;
      if (busWr) begin
        if (rampPage(busAddr)) begin
          // ramp time up to 6500.0 s
          rampTime[busAddr[3:2]] <= clampPair(busWdata, `DFA_RAMP_MAX, `DFA_RAMP_MAX);
        end
        case (busAddr)
          `DFA_ADDR_CTRL:    ctrl <= busWdata[6:0];
          `DFA_ADDR_JUMP:    jumpPts <= busWdata;
          // dead time up to 3000.0 s
          `DFA_ADDR_AMPDEAD: ampDead <= clampPair(busWdata, 16'hffff, `DFA_DEAD_MAX);
          `DFA_ADDR_DROOP:   droopRate <= clampTo(busWdata[`DFA_LO], `DFA_PCT2_MAX);
          `DFA_ADDR_HOURS:   hourThr <= clampPair(busWdata, `DFA_HOURS_MAX, `DFA_HOURS_MAX);
          `DFA_ADDR_LEVEL:   levelCfg <= clampPair(busWdata, 16'hffff, `DFA_PCT2_MAX);
          `DFA_ADDR_ARRIVE:  arriveCfg <= clampPair(busWdata, `DFA_PCT1_MAX, 16'hffff);
          `DFA_ADDR_LIMITS:  limits <= busWdata;
          `DFA_ADDR_DOSEL:   doSel <= busWdata[23:0];
          `DFA_ADDR_IRQMASK: irqMask <= busWdata[4:0];
          default:           ;
        endcase
      end
    end
  end

  // run sequencing, ramp and reversal dead time
  always @(posedge ref_clk) begin
    if (srst) begin
      state      <= `DFA_ST_IDLE;
      rampFreq   <= 16'h0;
      rampAcc    <= 48'h0;
      tenthCnt   <= 32'h0;
      deadCnt    <= 16'h0;
      outReverse <= 1'b0;
      lockout    <= 1'b0;
      armed      <= 1'b1;
    end else begin
      // armed lasts one cycle: the power-up command check looks once
      armed   <= 1'b0;
      lockout <= nextLock;
      if (coast) begin
        rampFreq <= 16'h0;
        rampAcc  <= 48'h0;
      end else if (rampFreq == tgt) begin
        rampAcc <= 48'h0;
      end else if (rampSel == 16'h0) begin
        rampFreq <= tgt;
        rampAcc  <= 48'h0;
      end else if (stepNow) begin
        rampAcc  <= accSum - rampLimit;
        rampFreq <= accel ? rampFreq + 16'h1 : rampFreq - 16'h1;
      end else begin
        rampAcc <= accSum;
      end
      case (state)
        `DFA_ST_IDLE: begin
          if (reqRun && rampFreq == 16'h0) begin
            outReverse <= wantRev;
            state      <= `DFA_ST_RUN;
          end
        end
        `DFA_ST_RUN: begin
          if (!reqRun && rampFreq == 16'h0) begin
            state <= `DFA_ST_IDLE;
          end else if (!dirOk && rampFreq == 16'h0) begin
            state    <= `DFA_ST_DEAD;
            tenthCnt <= 32'h0;
            deadCnt  <= 16'h0;
          end
        end
        // dead time counts whole tenths of a second at zero output
        `DFA_ST_DEAD: begin
          if (!reqRun) begin
            state <= `DFA_ST_IDLE;
          end else if (deadCnt >= deadTime) begin
            outReverse <= wantRev;
            state      <= `DFA_ST_RUN;
          end else if (tenthCnt >= TENTH_CYC - 1) begin
            tenthCnt <= 32'h0;
            deadCnt  <= deadCnt + 16'h1;
          end else begin
            tenthCnt <= tenthCnt + 32'h1;
          end
        end
        default: state <= `DFA_ST_IDLE;
      endcase
    end
  end

  // outputs and detections
  always @(posedge ref_clk) begin
    if (srst) begin
      outFreq              <= 16'h0;
      running              <= 1'b0;
      startMethod          <= `DFA_START_DIRECT;
      stopMethod           <= `DFA_STOP_DECEL;
      frequencyLevelDetect <= 1'b0;
      frequencyArrival     <= 1'b0;
      powerOnArr           <= 1'b0;
      runTimeArr           <= 1'b0;
      multiFunctionOutput  <= 4'h0;
      irq                  <= 1'b0;
    end else begin
      outFreq              <= nextFreq;
      running              <= notIdle;
      startMethod          <= jogCmd ? `DFA_START_DIRECT : ctrl[`DFA_CTRL_START];
      stopMethod           <= jogCmd ? `DFA_STOP_DECEL : ctrl[`DFA_CTRL_STOP];
      frequencyLevelDetect <= nextLevel;
      frequencyArrival     <= nextArr;
      powerOnArr           <= nextPwr;
      runTimeArr           <= nextRunT;
      // level interrupt from the status being written this cycle
      irq                  <= |(nextStat & irqMask);
      for (i = 0; i < 4; i = i + 1) begin
        multiFunctionOutput[i] <= doFunc(doSel[i*6 +: 6], notIdle, nextLevel,
                                         nextArr, nextRunT, nextPwr);
      end
    end
  end

endmodule // dfa_aux_logic
`default_nettype wire

//--- tb/dfa_motor_model.sv
// motor side model: load torque and hour meters
`timescale 1ns/1ps
`default_nettype none
module dfa_motor_model (
  input  wire logic        ref_clk,
  input  wire logic        running,
  input  wire logic        hourTick,
  input  wire logic [15:0] loadTorque,
  output var  logic [15:0] outputTorque,
  output var  logic [15:0] accumulatedPowerOnHours,
  output var  logic [15:0] accumulatedRunHours
);
  initial begin
    outputTorque = 16'h0000;
    accumulatedPowerOnHours = 16'h0000;
    accumulatedRunHours = 16'h0000;
  end
  // run hours only count while the drive is running
  always @(posedge ref_clk) begin
    outputTorque <= loadTorque;
    accumulatedPowerOnHours <= accumulatedPowerOnHours + {15'h0000, hourTick};
    accumulatedRunHours <= accumulatedRunHours + {15'h0000, hourTick & running};
  end
endmodule // dfa_motor_model
`default_nettype wire

//--- tb/dfa_aux_logic_sva.sv
// port assertions of the frequency auxiliary logic
`timescale 1ns/1ps
`default_nettype none
`include "dfa_defs.vh"
module dfa_aux_logic_sva (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic [7:0]  busAddr,
  input wire logic [31:0] busWdata,
  input wire logic        busWr,
  input wire logic        busRd,
  input wire logic [31:0] busRdata,
  input wire logic        jogCmd,
  input wire logic [15:0] accumulatedPowerOnHours,
  input wire logic [15:0] accumulatedRunHours,
  input wire logic [15:0] outFreq,
  input wire logic        outReverse,
  input wire logic        running,
  input wire logic [1:0]  startMethod,
  input wire logic        stopMethod,
  input wire logic        frequencyLevelDetect,
  input wire logic        frequencyArrival,
  input wire logic [3:0]  multiFunctionOutput
);
  logic [15:0] thr, hyst, rtThr, poThr;
  logic [11:0] sel;
  logic        noRev;
  logic [3:0]  rtOn, rtOff, poOn;
  wire  [31:0] lowMark = {16'h0000, thr} - ({16'h0000, thr} * {16'h0000, hyst}) / 32'h0000_2710;
  // shadow of the settings written over the bus
  always @(posedge ref_clk) begin
    if (srst) begin
      thr <= 16'h1388;
      hyst <= 16'h01f4;
      rtThr <= 16'h0000;
      poThr <= 16'h0000;
      sel <= 12'h000;
      noRev <= 1'b0;
    end else if (busWr && busAddr == `DFA_ADDR_LEVEL) begin
      thr <= busWdata[15:0];
      hyst <= busWdata[31:16];
    end else if (busWr && busAddr == `DFA_ADDR_HOURS) begin
      poThr <= busWdata[15:0];
      rtThr <= busWdata[31:16];
    end else if (busWr && busAddr == `DFA_ADDR_DOSEL) begin
      sel <= busWdata[11:0];
    end else if (busWr && busAddr == `DFA_ADDR_CTRL) begin
      noRev <= busWdata[`DFA_CTRL_NOREV];
    end
  end
  // history of arrival conditions, so register latency is tolerated
  always @(posedge ref_clk) begin
    if (srst) begin
      rtOn <= 4'h0;
      rtOff <= 4'h0;
      poOn <= 4'h0;
    end else begin
      rtOn <= {rtOn[2:0], sel[5:0] == 6'h0c && accumulatedRunHours >= rtThr};
      rtOff <= {rtOff[2:0], sel[5:0] == 6'h0c && accumulatedRunHours < rtThr};
      poOn <= {poOn[2:0], sel[11:6] == 6'h18 && accumulatedPowerOnHours >= poThr};
    end
  end
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_jog_fixed_mode: assert property (
    jogCmd && $past(jogCmd) && $past(jogCmd, 2) |-> startMethod == 2'h0 && !stopMethod)
    else $error("jog did not force direct start and ramp stop");
  a_rev_blocked: assert property (
    noRev && $past(noRev) && !outReverse |=> !outReverse)
    else $error("reverse entered while prohibited");
  a_level_rise: assert property (
    $rose(frequencyLevelDetect) |-> outFreq > thr || $past(outFreq) > thr)
    else $error("level output rose at or below threshold");
  a_level_fall: assert property (
    $fell(frequencyLevelDetect) |-> outFreq < lowMark || $past(outFreq) < lowMark)
    else $error("level output fell inside hysteresis");
  a_arrive_running: assert property (
    frequencyArrival |-> running || $past(running))
    else $error("arrival shown while stopped");
  a_read_idle: assert property (
    !$past(busRd) |-> busRdata == 32'h0000_0000)
    else $error("read data outside read slot");
  a_dead_zero: assert property (
    $changed(outReverse) |-> outFreq == 16'h0000 && $past(outFreq) == 16'h0000)
    else $error("direction changed at nonzero frequency");
  a_runtime_on: assert property (
    &rtOn |-> multiFunctionOutput[0])
    else $error("run time arrival output missing");
  a_runtime_off: assert property (
    &rtOff |-> !multiFunctionOutput[0])
    else $error("run time arrival output early");
  a_poweron_on: assert property (
    &poOn |-> multiFunctionOutput[1])
    else $error("power-on arrival output missing");
endmodule // dfa_aux_logic_sva
`default_nettype wire

//--- tb/dfa_aux_logic_tb.sv
// self-checking bench of the frequency auxiliary logic
`timescale 1ns/1ps
`default_nettype none
`include "dfa_defs.vh"
module dfa_aux_logic_tb;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  busAddr = 8'h00;
  logic [31:0] busWdata = 32'h0000_0000;
  logic        busWr = 1'b0;
  logic        busRd = 1'b0;
  logic        runCmd = 1'b1;
  logic        reverseCmd = 1'b0;
  logic        jogCmd = 1'b0;
  logic        faultReset = 1'b0;
  logic [1:0]  multiFunctionInput = 2'h0;
  logic [15:0] setFrequency = 16'h0000;
  logic [15:0] loadTorque = 16'h0000;
  logic        hourTick = 1'b0;
  logic [31:0] busRdata, rdv, cycles = 32'h0;
  logic [15:0] outputTorque, powerOnHours, runHours, outFreq;
  logic        outReverse, running, stopMethod, levelOut, arriveOut, irq;
  logic [1:0]  startMethod;
  logic [3:0]  mfo;
  int          errCount = 0;
  int          comparisons = 0;
  int          n;
  logic [15:0] jIn [5] = '{16'h0b54, 16'h0c1c, 16'h0c7f, 16'h0af1, 16'h0ce4};
  logic [15:0] jOut [5] = '{16'h0af0, 16'h0c80, 16'h0c80, 16'h0af0, 16'h0ce4};
  logic [15:0] lvIn [3] = '{16'h13ec, 16'h12c0, 16'h125c};
  logic        lvOut [3] = '{1'b1, 1'b1, 1'b0};
  logic [1:0]  llMode [3] = '{2'h0, 2'h2, 2'h1};
  logic [15:0] llFreq [3] = '{16'h03e8, 16'h0000, 16'h0000};
  logic        llRun [3] = '{1'b1, 1'b1, 1'b0};
  dfa_aux_logic #(.TENTH_CYC(10), .PROTECT_AT_RESET(1'b1)) dut (
    .ref_clk(ref_clk), .srst(srst), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr),
    .busRd(busRd), .busRdata(busRdata), .runCmd(runCmd), .reverseCmd(reverseCmd),
    .jogCmd(jogCmd), .faultReset(faultReset), .multiFunctionInput(multiFunctionInput),
    .setFrequency(setFrequency), .outputTorque(outputTorque),
    .accumulatedPowerOnHours(powerOnHours), .accumulatedRunHours(runHours),
    .outFreq(outFreq), .outReverse(outReverse), .running(running),
    .startMethod(startMethod), .stopMethod(stopMethod), .frequencyLevelDetect(levelOut),
    .frequencyArrival(arriveOut), .multiFunctionOutput(mfo), .irq(irq));
  dfa_motor_model motor (
    .ref_clk(ref_clk), .running(running), .hourTick(hourTick), .loadTorque(loadTorque),
    .outputTorque(outputTorque), .accumulatedPowerOnHours(powerOnHours),
    .accumulatedRunHours(runHours));
  always #25 ref_clk = ~ref_clk;
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    busAddr <= a;
    busWdata <= d;
    busWr <= 1'b1;
    tick(1);
    busWr <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a);
    busAddr <= a;
    busRd <= 1'b1;
    tick(1);
    busRd <= 1'b0;
    tick(1);
    rdv = busRdata;
  endtask
  task automatic pulse();
    hourTick <= 1'b1;
    tick(1);
    hourTick <= 1'b0;
    tick(1);
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errCount, comparisons);
    if (errCount == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 32'h1;
    if (cycles == 32'h0000_4e20) begin
      errCount++;
      report_and_stop();
    end
  end
  initial begin
    tick(6);
    srst <= 1'b0;
    wr(`DFA_ADDR_ARRIVE, 32'h2710_000a);
    wr(`DFA_ADDR_DOSEL, {8'h00, 6'h04, 6'h03, 6'h18, 6'h0c});
    wr(`DFA_ADDR_HOURS, 32'h0032_0064);
    wr(`DFA_ADDR_AMPDEAD, 32'h0002_00c8);
    wr(`DFA_ADDR_JUMP, 32'h0000_0bb8);
    rd(`DFA_ADDR_LEVEL);
    chk("levelReset", 32'h01f4_1388, rdv);
    chk("lockRun", 32'h0, {31'h0, running});
    rd(`DFA_ADDR_STATUS);
    chk("lockFlag", 32'h1, {31'h0, rdv[29]});
    runCmd <= 1'b0;
    tick(3);
    runCmd <= 1'b1;
    tick(4);
    chk("runAfterRelease", 32'h1, {31'h0, running});
    for (int i = 0; i < 5; i++) begin
      setFrequency <= jIn[i];
      tick(5);
      chk("jumpFreq", {16'h0, jOut[i]}, {16'h0, outFreq});
    end
    wr(`DFA_ADDR_JUMP, 32'h0000_0000);
    setFrequency <= jIn[0];
    tick(5);
    chk("jumpOff", {16'h0, jIn[0]}, {16'h0, outFreq});
    for (int i = 0; i < 3; i++) begin
      setFrequency <= lvIn[i];
      tick(6);
      chk("level", {31'h0, lvOut[i]}, {31'h0, levelOut});
      chk("arrival", 32'h1, {31'h0, arriveOut});
      chk("levelDo", {31'h0, lvOut[i]}, {31'h0, mfo[2]});
      chk("arrivalDo", 32'h1, {31'h0, mfo[3]});
    end
    chk("irqMasked", 32'h0, {31'h0, irq});
    rd(`DFA_ADDR_IRQSTAT);
    chk("irqStatus", 32'h1, {31'h0, rdv[`DFA_IRQ_LEVEL]});
    wr(`DFA_ADDR_IRQMASK, 32'h0000_0001);
    tick(3);
    chk("irqRaised", 32'h1, {31'h0, irq});
    wr(`DFA_ADDR_IRQSTAT, 32'h0000_0001);
    tick(3);
    chk("irqCleared", 32'h0, {31'h0, irq});
    setFrequency <= 16'h1388;
    loadTorque <= 16'h01f4;
    wr(`DFA_ADDR_DROOP, 32'h0000_0064);
    tick(6);
    chk("droopFreq", 32'h128e, {16'h0, outFreq});
    chk("droopArrival", 32'h0, {31'h0, arriveOut});
    wr(`DFA_ADDR_DROOP, 32'h0000_0000);
    wr(`DFA_ADDR_LIMITS, 32'h00c8_03e8);
    setFrequency <= 16'h01f4;
    for (int i = 0; i < 3; i++) begin
      wr(`DFA_ADDR_CTRL, {29'h0, llMode[i], 1'b1});
      tick(8);
      chk("lowFreq", {16'h0, llFreq[i]}, {16'h0, outFreq});
      chk("lowRun", {31'h0, llRun[i]}, {31'h0, running});
    end
    wr(`DFA_ADDR_CTRL, 32'h0000_0001);
    wr(`DFA_ADDR_LIMITS, 32'h00c8_0000);
    runCmd <= 1'b0;
    tick(3);
    runCmd <= 1'b1;
    wr(8'h1c, 32'hffff_ffff);
    rd(8'h1c);
    chk("rampClamp", 32'hfde8_fde8, rdv);
    wr(8'h18, 32'h0000_000a);
    multiFunctionInput <= 2'h2;
    setFrequency <= 16'h1388;
    tick(10);
    chk("rampSlow", 32'h1, {31'h0, outFreq > 16'h01f4 && outFreq < 16'h1388});
    multiFunctionInput <= 2'h0;
    tick(5);
    chk("rampFast", 32'h1388, {16'h0, outFreq});
    reverseCmd <= 1'b1;
    n = 0;
    while (outFreq !== 16'h0000 && n < 40) begin
      tick(1);
      n++;
    end
    n = 0;
    while (outReverse !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    chk("deadTime", 32'h1, {31'h0, n >= 18 && n <= 26});
    wr(`DFA_ADDR_CTRL, 32'h0000_0009);
    tick(80);
    chk("noReverse", 32'h0, {31'h0, outReverse});
    reverseCmd <= 1'b0;
    wr(`DFA_ADDR_CTRL, 32'h0000_0061);
    jogCmd <= 1'b1;
    tick(4);
    chk("jogMethods", 32'h0, {29'h0, startMethod, stopMethod});
    jogCmd <= 1'b0;
    tick(4);
    chk("normMethods", 32'h5, {29'h0, startMethod, stopMethod});
    wr(`DFA_ADDR_CTRL, 32'h0000_0001);
    repeat (49) pulse();
    tick(3);
    chk("runTimeEarly", 32'h0, {31'h0, mfo[0]});
    pulse();
    tick(3);
    chk("runTimeOut", 32'h1, {31'h0, mfo[0]});
    chk("powerOnEarly", 32'h0, {31'h0, mfo[1]});
    repeat (50) pulse();
    tick(3);
    chk("powerOnOut", 32'h1, {31'h0, mfo[1]});
    faultReset <= 1'b1;
    tick(1);
    faultReset <= 1'b0;
    tick(6);
    chk("faultLock", 32'h0, {31'h0, running});
    runCmd <= 1'b0;
    tick(3);
    runCmd <= 1'b1;
    tick(6);
    chk("faultUnlock", 32'h1, {31'h0, running});
    rd(8'h40);
    chk("unmapped", 32'h0, rdv);
    report_and_stop();
  end
endmodule // dfa_aux_logic_tb
bind dfa_aux_logic dfa_aux_logic_sva chk (
  .ref_clk(ref_clk), .srst(srst), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr),
  .busRd(busRd), .busRdata(busRdata), .jogCmd(jogCmd),
  .accumulatedPowerOnHours(accumulatedPowerOnHours), .accumulatedRunHours(accumulatedRunHours),
  .outFreq(outFreq), .outReverse(outReverse), .running(running), .startMethod(startMethod),
  .stopMethod(stopMethod), .frequencyLevelDetect(frequencyLevelDetect),
  .frequencyArrival(frequencyArrival), .multiFunctionOutput(multiFunctionOutput));
`default_nettype wire
